// >>> design/xfe_defines.vh
// Purpose: constants for the descriptor transfer engine
// Assumes: 32-bit descriptor words, 24-bit memory addresses
// Notes: register offsets are byte addresses on the wishbone port
// Overview of operation
// R1: fetch descriptor, transfer, write descriptor back
// R2: 24-bit pointers step independently after transfers
// R3: vector holds descriptor start, then load it
// R4: chain enable loads next consecutive descriptor
// R5: chain-on-zero chains only when counter zero
// R6: chained descriptor raises no irq, keeps flag
// R7: normal mode one unit, 1 to 65536
// R8: repeat mode, high byte reloads low byte
// R9: repeat expiry restores counter and area pointer
// R10: repeat mode never requests irq by count
// R11: block mode moves block of 1..256 units
// R12: block end reloads counter, area; steps other
// R13: block count in count_b, irq when done
// R14: irq on count end or irq_every_transfer
// R15: software activation uses soft done irq
// R16: soft irq keeps soft_activate set
// R17: software clears soft_activate after soft irq
// R18: no soft irq while soft transfer pending
// R19: count end clears vector enable, forwards irq
// R20: plain soft transfer clears soft_activate
// R21: step is 1 for byte, 2 for word
`ifndef XFE_DEFINES_VH
`define XFE_DEFINES_VH
// register byte offsets
`define XFE_OFS_CTRL 8'h00
`define XFE_OFS_ENABLE 8'h04
`define XFE_OFS_STATUS 8'h08
// control register fields
`define XFE_CTRL_SOFT 8
`define XFE_CTRL_VEC 7:0
// mode_word_a fields
`define XFE_MA_SRC 7:6
`define XFE_MA_DST 5:4
`define XFE_MA_MODE 3:2
`define XFE_MA_AREA 1
`define XFE_MA_WORD 0
// mode_word_b fields
`define XFE_MB_CHAIN 7
`define XFE_MB_EVERY 6
`define XFE_MB_ONZERO 5
// transfer modes
`define XFE_MODE_NORMAL 2'h0
`define XFE_MODE_REPEAT 2'h1
`define XFE_MODE_BLOCK 2'h2
// pointer step selections
`define XFE_STEP_INC 2'h2
`define XFE_STEP_DEC 2'h3
// memory access sizes
`define XFE_SIZE_BYTE 2'h0
`define XFE_SIZE_WORD 2'h1
`define XFE_SIZE_LONG 2'h2
// vector table and descriptor layout
`define XFE_VEC_BASE 24'h000400
`define XFE_WORD_BYTES 24'h000004
`define XFE_DESC_BYTES 24'h00000c
`endif

// >>> design/xfe_regs.v
// Purpose: wishbone register slave for the transfer engine
// Assumes: classic single cycles, one aligned word per register
// Notes: answers one cycle after the request, unmapped reads zero
`timescale 1ns/100ps
`include "xfe_defines.vh"
module xfe_regs #(
  parameter SRC_NUM = 8
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // engine side
  input wire [SRC_NUM-1:0] enClr,
  input wire softClr,
  input wire softTake,
  input wire softIrqSet,
  input wire busy,
  output reg [SRC_NUM-1:0] enableQ,
  output reg softActQ,
  output reg [7:0] softVecQ,
  output reg softPendQ,
  output reg softDoneIrqQ
);
  wire req = wb_cyc_i & wb_stb_i;
  // write takes effect at the edge where the master samples ack
  wire wr = req & wb_we_i & wb_ack_o;
  wire wrCtrl = wr & (wb_adr_i == `XFE_OFS_CTRL);
  wire wrEn = wr & (wb_adr_i == `XFE_OFS_ENABLE);
  wire softWr = wrCtrl & wb_sel_i[1];
  wire softNew = wb_dat_i[`XFE_CTRL_SOFT];
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      enableQ <= {SRC_NUM{1'b0}};
      softActQ <= 1'b0;
      softVecQ <= 8'h00;
      softPendQ <= 1'b0;
      softDoneIrqQ <= 1'b0;
    end else begin
      wb_ack_o <= req & ~wb_ack_o;
      if (req & ~wb_ack_o) begin
        case (wb_adr_i)
          `XFE_OFS_CTRL: wb_dat_o <= {23'h000000, softActQ, softVecQ};
          `XFE_OFS_ENABLE: wb_dat_o <= {{(32-SRC_NUM){1'b0}}, enableQ};
          `XFE_OFS_STATUS: wb_dat_o <= {30'h00000000, softDoneIrqQ, busy};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      // hardware clear of an enable wins over a same-cycle write
      if (wrEn & wb_sel_i[0])
        enableQ <= wb_dat_i[SRC_NUM-1:0] & ~enClr;
      else
        enableQ <= enableQ & ~enClr; // R19
      if (wrCtrl & wb_sel_i[0])
        softVecQ <= wb_dat_i[`XFE_CTRL_VEC];
      if (softWr)
        softActQ <= softNew;
      else if (softClr)
        softActQ <= 1'b0; // R20
      // a request only starts on a 0 to 1 write of soft_activate
      if (softWr & softNew & ~softActQ)
        softPendQ <= 1'b1;
      else if (softTake)
        softPendQ <= 1'b0;
      // set wins over the clear done by writing soft_activate 0
      if (softIrqSet)
        softDoneIrqQ <= 1'b1; // R16
      else if (softWr & ~softNew)
        softDoneIrqQ <= 1'b0; // R17
    end
  end
endmodule // xfe_regs

// >>> design/xfe_engine.v
// Purpose: descriptor driven byte and word transfer engine
// Assumes: memory port answers with a one-cycle ack per access
// Notes: one activation served at a time, lowest source first
//
// The Wishbone register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
`include "xfe_defines.vh"
module xfe_engine #(
  parameter SRC_NUM = 8,
  parameter IDX_W = 3
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  // activation sources
  input wire [SRC_NUM-1:0] srcReq,
  output reg [SRC_NUM-1:0] srcClearQ,
  output reg [SRC_NUM-1:0] srcFwdQ,
  output wire softDoneIrq,
  output wire busy,
  // memory master
  output reg memReqQ,
  output reg memWeQ,
  output reg [23:0] memAddrQ,
  output reg [1:0] memSizeQ,
  output reg [31:0] memWdataQ,
  input wire [31:0] memRdata,
  input wire memAck
);
  localparam S_IDLE = 4'h0;
  localparam S_VEC = 4'h1;
  localparam S_RD0 = 4'h2;
  localparam S_RD1 = 4'h3;
  localparam S_RD2 = 4'h4;
  localparam S_DRD = 4'h5;
  localparam S_DWR = 4'h6;
  localparam S_WB0 = 4'h7;
  localparam S_WB1 = 4'h8;
  localparam S_WB2 = 4'h9;
  localparam S_END = 4'ha;

  reg [3:0] stateQ;
  reg softSrcQ;
  reg [IDX_W-1:0] idxQ;
  reg [23:0] descQ;
  reg [7:0] modeAQ;
  reg [7:0] modeBQ;
  reg [23:0] srcPQ;
  reg [23:0] dstPQ;
  reg [15:0] cntAQ;
  reg [15:0] cntBQ;
  reg doneQ;
  reg [SRC_NUM-1:0] enClrQ;
  reg softClrQ;
  reg softTakeQ;
  reg softIrqQ;
  wire [SRC_NUM-1:0] enableQ;
  wire softPend;
  wire [7:0] softVec;

  xfe_regs #(
    .SRC_NUM(SRC_NUM)
  ) u_regs (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .enClr(enClrQ),
    .softClr(softClrQ),
    .softTake(softTakeQ),
    .softIrqSet(softIrqQ),
    .busy(busy),
    .enableQ(enableQ),
    .softActQ(),
    .softVecQ(softVec),
    .softPendQ(softPend),
    .softDoneIrqQ(softDoneIrq)
  );

  assign busy = (stateQ != S_IDLE);

  function [IDX_W-1:0] firstSet;
    input [SRC_NUM-1:0] v;
    integer i;
    begin
      firstSet = {IDX_W{1'b0}};
      for (i = SRC_NUM - 1; i >= 0; i = i - 1)
        if (v[i])
          firstSet = i[IDX_W-1:0];
    end
  endfunction

  function [SRC_NUM-1:0] oneHot;
    input [IDX_W-1:0] n;
    begin
      oneHot = {{(SRC_NUM-1){1'b0}}, 1'b1} << n;
    end
  endfunction

  // step by 1 for bytes, 2 for words
  function [23:0] stepPtr;
    input [23:0] p;
    input [1:0] m;
    input w;
    begin
      case (m)
        `XFE_STEP_INC: stepPtr = p + (w ? 24'h000002 : 24'h000001); // R21
        `XFE_STEP_DEC: stepPtr = p - (w ? 24'h000002 : 24'h000001); // R21
        default: stepPtr = p;
      endcase
    end
  endfunction

  // start of the area, from the pointer of its last unit; hm1 is
  // the unit count less one, so a count of 0 means 256 units
  function [23:0] restorePtr;
    input [23:0] p;
    input [1:0] m;
    input w;
    input [7:0] hm1;
    reg [23:0] ofs;
    begin
      ofs = w ? {15'h0000, hm1, 1'b0} : {16'h0000, hm1};
      case (m)
        `XFE_STEP_INC: restorePtr = p - ofs;
        `XFE_STEP_DEC: restorePtr = p + ofs;
        default: restorePtr = p;
      endcase
    end
  endfunction

  function [23:0] vecAddr;
    input [7:0] v;
    begin
      vecAddr = `XFE_VEC_BASE + {14'h0000, v, 2'b00};
    end
  endfunction

  wire [1:0] mode = modeAQ[`XFE_MA_MODE];
  wire word = modeAQ[`XFE_MA_WORD];
  wire areaSrc = modeAQ[`XFE_MA_AREA];
  wire chain = modeBQ[`XFE_MB_CHAIN];
  wire every = modeBQ[`XFE_MB_EVERY];
  wire onZero = modeBQ[`XFE_MB_ONZERO];
  wire [1:0] sizeSel = word ? `XFE_SIZE_WORD : `XFE_SIZE_BYTE;
  wire [SRC_NUM-1:0] pend = srcReq & enableQ;
  wire [7:0] lowDec = cntAQ[7:0] - 8'h01;
  wire [7:0] hm1 = cntAQ[15:8] - 8'h01;

  // pointer and counter update after one unit
  reg [23:0] srcN;
  reg [23:0] dstN;
  reg [15:0] cntAN;
  reg [15:0] cntBN;
  reg blkEnd;
  reg cntDone;
  always @* begin
    srcN = stepPtr(srcPQ, modeAQ[`XFE_MA_SRC], word); // R2
    dstN = stepPtr(dstPQ, modeAQ[`XFE_MA_DST], word); // R2
    cntAN = cntAQ;
    cntBN = cntBQ;
    blkEnd = 1'b1;
    cntDone = 1'b0;
    case (mode)
      `XFE_MODE_REPEAT: begin
        cntAN = {cntAQ[15:8], lowDec}; // R8
        if (lowDec == 8'h00) begin
          cntAN = {cntAQ[15:8], cntAQ[15:8]}; // R9
          if (areaSrc)
            srcN = restorePtr(srcPQ, modeAQ[`XFE_MA_SRC], word, hm1); // R9
          else
            dstN = restorePtr(dstPQ, modeAQ[`XFE_MA_DST], word, hm1); // R9
        end
        cntDone = 1'b0; // R10
      end
      `XFE_MODE_BLOCK: begin
        cntAN = {cntAQ[15:8], lowDec}; // R11
        blkEnd = (lowDec == 8'h00); // R11
        if (blkEnd) begin
          cntAN = {cntAQ[15:8], cntAQ[15:8]}; // R12
          if (areaSrc)
            srcN = restorePtr(srcPQ, modeAQ[`XFE_MA_SRC], word, hm1); // R12
          else
            dstN = restorePtr(dstPQ, modeAQ[`XFE_MA_DST], word, hm1); // R12
          cntBN = cntBQ - 16'h0001; // R13
          cntDone = (cntBN == 16'h0000); // R13
        end
      end
      default: begin
        // count_b is not touched here; 0 counts as 65536
        cntAN = cntAQ - 16'h0001; // R7
        cntDone = (cntAN == 16'h0000); // R7
      end
    endcase
  end

  // chain-on-zero breaks the chain unless the count ran out
  wire goChain = chain & (~onZero | doneQ); // R5
  // a chained descriptor never interrupts, even if the chain breaks
  wire wantIrq = ~chain & (every | doneQ); // R6

  task issue;
    input we;
    input [23:0] a;
    input [1:0] sz;
    input [31:0] d;
    begin
      memReqQ <= 1'b1;
      memWeQ <= we;
      memAddrQ <= a;
      memSizeQ <= sz;
      memWdataQ <= d;
    end
  endtask

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stateQ <= S_IDLE;
      softSrcQ <= 1'b0;
      idxQ <= {IDX_W{1'b0}};
      descQ <= 24'h000000;
      modeAQ <= 8'h00;
      modeBQ <= 8'h00;
      srcPQ <= 24'h000000;
      dstPQ <= 24'h000000;
      cntAQ <= 16'h0000;
      cntBQ <= 16'h0000;
      doneQ <= 1'b0;
      enClrQ <= {SRC_NUM{1'b0}};
      softClrQ <= 1'b0;
      softTakeQ <= 1'b0;
      softIrqQ <= 1'b0;
      srcClearQ <= {SRC_NUM{1'b0}};
      srcFwdQ <= {SRC_NUM{1'b0}};
      memReqQ <= 1'b0;
      memWeQ <= 1'b0;
      memAddrQ <= 24'h000000;
      memSizeQ <= `XFE_SIZE_BYTE;
      memWdataQ <= 32'h00000000;
    end else begin
      enClrQ <= {SRC_NUM{1'b0}};
      softClrQ <= 1'b0;
      softTakeQ <= 1'b0;
      softIrqQ <= 1'b0; // R18
      srcClearQ <= {SRC_NUM{1'b0}};
      srcFwdQ <= {SRC_NUM{1'b0}};
      if (memAck)
        memReqQ <= 1'b0;
      case (stateQ)
        S_IDLE: begin
          // peripheral sources take priority over software
          if (|pend) begin
            softSrcQ <= 1'b0;
            idxQ <= firstSet(pend);
            issue(1'b0, vecAddr({{(8-IDX_W){1'b0}}, firstSet(pend)}),
                  `XFE_SIZE_LONG, 32'h00000000); // R3
            stateQ <= S_VEC;
          end else if (softPend) begin
            softSrcQ <= 1'b1;
            softTakeQ <= 1'b1;
            issue(1'b0, vecAddr(softVec), `XFE_SIZE_LONG,
                  32'h00000000); // R3
            stateQ <= S_VEC;
          end
        end
        S_VEC: if (memAck) begin
          descQ <= memRdata[23:0]; // R3
          issue(1'b0, memRdata[23:0], `XFE_SIZE_LONG, 32'h00000000);
          stateQ <= S_RD0;
        end
        S_RD0: if (memAck) begin
          {modeAQ, srcPQ} <= memRdata; // R1
          issue(1'b0, descQ + `XFE_WORD_BYTES, `XFE_SIZE_LONG,
                32'h00000000);
          stateQ <= S_RD1;
        end
        S_RD1: if (memAck) begin
          {modeBQ, dstPQ} <= memRdata; // R1
          issue(1'b0, descQ + (`XFE_WORD_BYTES << 1), `XFE_SIZE_LONG,
                32'h00000000);
          stateQ <= S_RD2;
        end
        S_RD2: if (memAck) begin
          {cntAQ, cntBQ} <= memRdata; // R1
          doneQ <= 1'b0;
          issue(1'b0, srcPQ, sizeSel, 32'h00000000);
          stateQ <= S_DRD;
        end
        S_DRD: if (memAck) begin
          issue(1'b1, dstPQ, sizeSel, {16'h0000, memRdata[15:0]});
          stateQ <= S_DWR;
        end
        S_DWR: if (memAck) begin
          srcPQ <= srcN; // R2
          dstPQ <= dstN; // R2
          cntAQ <= cntAN;
          cntBQ <= cntBN;
          doneQ <= cntDone;
          // inside a block the next unit follows at once
          if (!blkEnd) begin
            issue(1'b0, srcN, sizeSel, 32'h00000000); // R11
            stateQ <= S_DRD;
          end else begin
            issue(1'b1, descQ, `XFE_SIZE_LONG, {modeAQ, srcN}); // R1
            stateQ <= S_WB0;
          end
        end
        S_WB0: if (memAck) begin
          issue(1'b1, descQ + `XFE_WORD_BYTES, `XFE_SIZE_LONG,
                {modeBQ, dstPQ}); // R1
          stateQ <= S_WB1;
        end
        S_WB1: if (memAck) begin
          issue(1'b1, descQ + (`XFE_WORD_BYTES << 1), `XFE_SIZE_LONG,
                {cntAQ, cntBQ}); // R1
          stateQ <= S_WB2;
        end
        S_WB2: if (memAck) begin
          if (goChain) begin
            descQ <= descQ + `XFE_DESC_BYTES; // R4
            issue(1'b0, descQ + `XFE_DESC_BYTES, `XFE_SIZE_LONG,
                  32'h00000000); // R4
            stateQ <= S_RD0;
          end else begin
            stateQ <= S_END;
            if (softSrcQ) begin
              if (wantIrq)
                softIrqQ <= 1'b1; // R15
              else
                softClrQ <= 1'b1; // R20
            end else if (wantIrq) begin
              srcFwdQ <= oneHot(idxQ); // R14
              enClrQ <= oneHot(idxQ); // R19
            end else if (!chain) begin
              srcClearQ <= oneHot(idxQ); // R6
            end
          end
        end
        // one idle cycle lets the source flag and enables settle
        S_END: stateQ <= S_IDLE;
        default: stateQ <= S_IDLE;
      endcase
    end
  end
endmodule // xfe_engine

// >>> sim/xfe_engine_sva.sv
// Purpose: port checker for the transfer engine
// Assumes: memory partner acks each held request once
// Notes: attached to every engine instance by bind
`timescale 1ns/100ps
module xfe_engine_sva #(
  parameter SRC_NUM = 8
) (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // register bus
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  // sources and interrupts
  input wire [SRC_NUM-1:0] srcReq,
  input wire [SRC_NUM-1:0] srcClearQ,
  input wire [SRC_NUM-1:0] srcFwdQ,
  input wire softDoneIrq,
  input wire busy,
  // memory master
  input wire memReqQ,
  input wire memWeQ,
  input wire [23:0] memAddrQ,
  input wire [1:0] memSizeQ,
  input wire [31:0] memWdataQ,
  input wire memAck
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  ack_next_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("register access not answered next cycle");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("register ack longer than one cycle");
  mem_hold_a: assert property (memReqQ && !memAck |=> memReqQ
    && $stable(memAddrQ) && $stable(memWeQ) && $stable(memSizeQ)
    && $stable(memWdataQ)) else $error("memory request not held");
  end_after_wb_a: assert property (|(srcFwdQ | srcClearQ)
    |-> $past(memAck) && $past(memWeQ)) else $error("end before writeback");
  fwd_pulse_a: assert property (|srcFwdQ |=> srcFwdQ == '0)
    else $error("forward pulse too long");
  fwd_excl_a: assert property ((srcFwdQ & srcClearQ) == '0)
    else $error("forwarded source flag also cleared");
  fwd_src_a: assert property (|srcFwdQ |-> (srcFwdQ & ~srcReq) == '0
    && !memReqQ) else $error("forward without its request");
  soft_after_a: assert property ($rose(softDoneIrq) |-> !memReqQ
    && $past(busy)) else $error("soft done raised during transfer");
  vec_first_a: assert property ($rose(busy) |-> ##[0:2] (memReqQ
    && !memWeQ && memSizeQ == 2'h2 && memAddrQ[23:10] == 14'h0001))
    else $error("activation did not start with vector read");
  cover property (|srcFwdQ);
  cover property ($rose(softDoneIrq));
  cover property (memReqQ && memWeQ && memSizeQ == 2'h1);
endmodule // xfe_engine_sva
bind xfe_engine xfe_engine_sva #(.SRC_NUM(SRC_NUM)) xfe_engine_sva_i (
  .core_clk(core_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .srcReq(srcReq),
  .srcClearQ(srcClearQ), .srcFwdQ(srcFwdQ), .softDoneIrq(softDoneIrq),
  .busy(busy), .memReqQ(memReqQ), .memWeQ(memWeQ), .memAddrQ(memAddrQ),
  .memSizeQ(memSizeQ), .memWdataQ(memWdataQ), .memAck(memAck));

// >>> sim/xfe_mem_model.sv
// Purpose: on-chip memory seen by the engine's master port
// Assumes: little-endian bytes, 4 kbyte decoded
// Notes: read data turns over when idle so stale data never looks valid
`timescale 1ns/100ps
module xfe_mem_model (
  // clock and reset
  input wire core_clk,
  input wire rst_n,
  // wait states before each ack
  input wire [1:0] lat,
  // memory slave
  input wire memReqQ,
  input wire memWeQ,
  input wire [23:0] memAddrQ,
  input wire [1:0] memSizeQ,
  input wire [31:0] memWdataQ,
  output logic [31:0] memRdata,
  output logic memAck
);
  logic [7:0] mem [0:4095];
  logic [1:0] waitQ;
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      memAck <= 1'b0;
      waitQ <= 2'h0;
      memRdata <= 32'h0;
    end else if (memReqQ && !memAck && waitQ == lat) begin
      memAck <= 1'b1;
      waitQ <= 2'h0;
      for (int k = 0; k < 4; k++) begin
        memRdata[8*k +: 8] <= 8'h00;
        if (k < (1 << memSizeQ) && memWeQ)
          mem[memAddrQ[11:0] + k] <= memWdataQ[8*k +: 8];
        else if (k < (1 << memSizeQ))
          memRdata[8*k +: 8] <= mem[memAddrQ[11:0] + k];
      end
    end else begin
      memAck <= 1'b0;
      memRdata <= ~memRdata;
      if (memReqQ && !memAck)
        waitQ <= waitQ + 2'h1;
    end
  end
endmodule // xfe_mem_model

// >>> sim/xfe_engine_test.sv
// Purpose: self-checking bench for the transfer engine
// Assumes: register map 0x00 control, 0x04 enable, 0x08 status
// Notes: source requests drop after the engine's end pulse
`timescale 1ns/100ps
module xfe_engine_test;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDat = 32'h0, rd;
  logic [7:0] srcReq = 8'h00, srcSet = 8'h00;
  logic [1:0] lat = 2'h0;
  wire [31:0] wbDatO, memRdata, memWdataQ;
  wire wbAck, busy, softDoneIrq, memReqQ, memWeQ, memAck;
  wire [7:0] srcClearQ, srcFwdQ;
  wire [23:0] memAddrQ;
  wire [1:0] memSizeQ;
  int n_errors = 0, checks = 0, nFwd = 0, nClr = 0;
  xfe_engine xfe_engine_i (.core_clk(core_clk), .rst_n(rst_n),
    .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr),
    .wb_sel_i(4'hf), .wb_dat_i(wbDat), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .srcReq(srcReq), .srcClearQ(srcClearQ), .srcFwdQ(srcFwdQ),
    .softDoneIrq(softDoneIrq), .busy(busy), .memReqQ(memReqQ),
    .memWeQ(memWeQ), .memAddrQ(memAddrQ), .memSizeQ(memSizeQ),
    .memWdataQ(memWdataQ), .memRdata(memRdata), .memAck(memAck));
  xfe_mem_model xfe_mem_model_i (.core_clk(core_clk), .rst_n(rst_n),
    .lat(lat), .memReqQ(memReqQ), .memWeQ(memWeQ), .memAddrQ(memAddrQ),
    .memSizeQ(memSizeQ), .memWdataQ(memWdataQ), .memRdata(memRdata),
    .memAck(memAck));
  initial forever #2 core_clk = ~core_clk;
  // a real source drops its flag once the engine has handled it
  always @(posedge core_clk) begin
    nFwd += (srcFwdQ != 8'h00);
    nClr += (srcClearQ != 8'h00);
    srcReq <= (srcReq | srcSet) & ~(srcFwdQ | srcClearQ);
  end
  task automatic end_of_test;
    $display("n_errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #200000;
    n_errors++;
    end_of_test();
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= a;
    wbDat <= d;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 40);
    if (wbAck !== 1'b1) begin
      n_errors++;
      $display("MISMATCH t=%0t no register ack", $time);
    end
    rd = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask
  task automatic put(input logic [11:0] a, input logic [31:0] d);
    for (int k = 0; k < 4; k++)
      xfe_mem_model_i.mem[a + k] = d[8*k +: 8];
  endtask
  function automatic logic [31:0] get(input logic [11:0] a);
    return {xfe_mem_model_i.mem[a + 3], xfe_mem_model_i.mem[a + 2],
      xfe_mem_model_i.mem[a + 1], xfe_mem_model_i.mem[a]};
  endfunction
  function automatic logic [7:0] m8(input logic [11:0] a);
    return xfe_mem_model_i.mem[a];
  endfunction
  task automatic blk(input logic [11:0] at, input logic [31:0] w0, w1, w2);
    put(at, w0);
    put(at + 12'h4, w1);
    put(at + 12'h8, w2);
  endtask
  task automatic desc(input logic [7:0] v, input logic [11:0] at,
    input logic [31:0] w0, w1, w2);
    put(12'h400 + {v, 2'b00}, {20'h0, at});
    blk(at, w0, w1, w2);
  endtask
  task automatic chkd(input logic [11:0] at, input logic [31:0] w0, w1, w2);
    chk(get(at), w0);
    chk(get(at + 12'h4), w1);
    chk(get(at + 12'h8), w2);
  endtask
  task automatic chkp(input int f, input int c);
    chk(nFwd, f);
    chk(nClr, c);
    nFwd = 0;
    nClr = 0;
  endtask
  task automatic settle;
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (busy !== 1'b1 && n < 20);
    while ((busy !== 1'b0 || srcReq != 8'h00) && n < 3000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 3000) begin
      n_errors++;
      $display("MISMATCH t=%0t engine did not finish", $time);
    end
  endtask
  // one process owns srcReq, so a raise cannot race the drop logic
  task automatic run(input logic [2:0] i);
    @(posedge core_clk);
    srcSet <= 8'h01 << i;
    @(posedge core_clk);
    srcSet <= 8'h00;
    settle();
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst_n <= 1'b1;
    wb(0, 8'h04, 0);
    chk(rd, 32'h0);
    wb(0, 8'h0c, 0);
    chk(rd, 32'h0);
    wb(1, 8'h04, 32'hff);
    // normal byte, count 2, count_b untouched
    desc(0, 12'h100, 32'ha0000800, 32'h00000900, 32'h00021234);
    put(12'h800, 32'h0000c35a);
    run(0);
    chk(m8(12'h900), 8'h5a);
    chkd(12'h100, 32'ha0000801, 32'h00000901, 32'h00011234);
    chkp(0, 1);
    run(0);
    chk(m8(12'h901), 8'hc3);
    chkd(12'h100, 32'ha0000802, 32'h00000902, 32'h00001234);
    chkp(1, 0);
    wb(0, 8'h04, 0);
    chk(rd, 32'hfe);
    // word, source decrements, slow memory, interrupt every transfer
    wb(1, 8'h04, 32'hff);
    lat <= 2'h2;
    desc(1, 12'h110, 32'hc1000820, 32'h40000920, 32'h00050000);
    put(12'h820, 32'h00001234);
    run(1);
    chk(m8(12'h921), 8'h12);
    chkd(12'h110, 32'hc100081e, 32'h40000920, 32'h00040000);
    chkp(1, 0);
    lat <= 2'h0;
    // chain with interrupt bit set on the first descriptor
    desc(2, 12'h120, 32'ha0000840, 32'hc0000940, 32'h00030000);
    blk(12'h12c, 32'ha0000848, 32'h00000948, 32'h00010000);
    put(12'h840, 32'h11);
    put(12'h848, 32'h22);
    run(2);
    chk(m8(12'h948), 8'h22);
    chkd(12'h120, 32'ha0000841, 32'hc0000941, 32'h00020000);
    chk(get(12'h134), 32'h0);
    chkp(1, 0);
    // chain only at zero: first run ends silently, flag stays up
    desc(3, 12'h140, 32'ha0000860, 32'ha0000960, 32'h00020000);
    blk(12'h14c, 32'ha0000868, 32'h00000968, 32'h00010000);
    put(12'h860, 32'h5544);
    put(12'h868, 32'h66);
    run(3);
    chk(m8(12'h961), 8'h55);
    chk(m8(12'h968), 8'h66);
    chk(get(12'h148), 32'h0);
    chk(get(12'h154), 32'h0);
    chkp(1, 0);
    // repeat of 2 with source as repeat area
    desc(4, 12'h160, 32'ha6000880, 32'h00000980, 32'h02020000);
    put(12'h880, 32'h8877);
    run(4);
    run(4);
    chk(m8(12'h981), 8'h88);
    chkd(12'h160, 32'ha6000880, 32'h00000982, 32'h02020000);
    chkp(0, 2);
    // one block of 2 with destination as block area
    desc(5, 12'h180, 32'ha80008a0, 32'h000009a0, 32'h02020001);
    put(12'h8a0, 32'haa99);
    run(5);
    chk(m8(12'h9a1), 8'haa);
    chkd(12'h180, 32'ha80008a2, 32'h000009a0, 32'h02020000);
    chkp(1, 0);
    // software activation on vector 6
    desc(6, 12'h1a0, 32'ha00008c0, 32'h000009c0, 32'h00020000);
    put(12'h8c0, 32'hccbb);
    wb(1, 8'h00, 32'h106);
    settle();
    chk(m8(12'h9c0), 8'hbb);
    wb(0, 8'h00, 0);
    chk(rd, 32'h006);
    wb(1, 8'h00, 32'h106);
    settle();
    chk(softDoneIrq, 1);
    wb(0, 8'h00, 0);
    chk(rd, 32'h106);
    wb(0, 8'h08, 0);
    chk(rd, 32'h2);
    wb(1, 8'h00, 32'h006);
    wb(0, 8'h08, 0);
    chk(rd, 32'h0);
    chkp(0, 0);
    end_of_test();
  end
endmodule // xfe_engine_test
